//--- src/atass_consts.svh
// Constants for the standby and S.M.A.R.T. status block
`ifndef ATASS_CONSTS_SVH
`define ATASS_CONSTS_SVH
// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define ATASS_CMD_STBY_A      8'he2
`define ATASS_CMD_STBY_B      8'h96
`define ATASS_CMD_STBYI_A     8'he0
`define ATASS_CMD_STBYI_B     8'h94
`define ATASS_CMD_SMART       8'hb0
// ----------------------------------------------------------------
// S.M.A.R.T. key and subcommands
// ----------------------------------------------------------------
`define ATASS_KEY_LOW         8'h4f
`define ATASS_KEY_HIGH        8'hc2
`define ATASS_SUB_RD_ATTR     8'hd0
`define ATASS_SUB_RD_THR      8'hd1
`define ATASS_SUB_AUTOSAVE    8'hd2
`define ATASS_SUB_SAVE_ATTR   8'hd3
`define ATASS_SUB_OFFLINE     8'hd4
`define ATASS_SUB_RD_LOG      8'hd5
`define ATASS_SUB_WR_LOG      8'hd6
`define ATASS_SUB_ENABLE      8'hd8
`define ATASS_SUB_DISABLE     8'hd9
`define ATASS_SUB_STATUS      8'hda
// ----------------------------------------------------------------
// Status and error values
// ----------------------------------------------------------------
`define ATASS_STAT_FAIL       8'h51
`define ATASS_STAT_OK         8'h50
`define ATASS_STAT_BUSY       8'h80
`define ATASS_ERR_NONE        8'h00
`define ATASS_ERR_ABORT       8'h04
`define ATASS_ERR_RD_FAIL     8'h40
`define ATASS_ERR_WR_FAIL     8'h01
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ATASS_CLK_PERIOD_NS   10
`define ATASS_TICK_NS         1000000000
`define ATASS_APD_UNIT_SEC    5
`define ATASS_APD_ZERO_MIN    109
`define ATASS_SEC_PER_MIN     60
`endif

//--- src/atass_pkg.sv
// Types shared by the standby and S.M.A.R.T. status block
package atass_pkg;
    typedef enum logic [4:0] {
        ATASS_ST_IDLE    = 5'b00001,
        ATASS_ST_FLUSH   = 5'b00010,
        ATASS_ST_SPINDN  = 5'b00100,
        ATASS_ST_SPINUP  = 5'b01000,
        ATASS_ST_SMART   = 5'b10000
    } atass_state_t;
    typedef logic [12:0] atass_sec_t;
endpackage : atass_pkg

//--- src/atass_tmr_if.sv
// Link between command logic and the auto power-down timer
`timescale 1ns/1ns
interface atass_tmr_if;
    import atass_pkg::*;
    logic       load;
    logic [7:0] code;
    logic       run;
    logic       reload;
    logic       expire;
    atass_sec_t interval;
    modport ctl (output load, code, run, reload, input expire, interval);
    modport tmr (input load, code, run, reload, output expire, interval);
endinterface : atass_tmr_if

//--- src/atass_apd_timer.sv
// Auto power-down timer with one-second prescaler
`timescale 1ns/1ns
`include "atass_consts.svh"
module atass_apd_timer import atass_pkg::*; #(
    parameter int TICK_CYCLES = `ATASS_TICK_NS / `ATASS_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // Control link
    atass_tmr_if.tmr  tif
);
    // Prescaler needs at least one cycle per second
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 1");
    end

    logic [31:0] pre_reg;
    logic        enabled_reg;
    atass_sec_t  interval_reg;
    atass_sec_t  cnt_reg;
    logic        expire_reg;
    atass_sec_t  interval_next;
    logic        tick;
    logic        dec;

    // ------------------------------------------------------------
    // Interval decode
    // ------------------------------------------------------------
    // Zero means 109 minutes
    assign interval_next = (tif.code == 8'h00) ?
        atass_sec_t'(`ATASS_APD_ZERO_MIN * `ATASS_SEC_PER_MIN) :
        atass_sec_t'(tif.code * `ATASS_APD_UNIT_SEC);
    assign tick = (pre_reg == 32'(TICK_CYCLES - 1));
    assign dec  = tick && tif.run && enabled_reg && (cnt_reg != '0);
    assign tif.expire   = expire_reg;
    assign tif.interval = interval_reg;

    // Prescaler free-runs; first second may be short by under a tick
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) pre_reg <= 32'h0;
        else pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
    end

    // Interval store, enable and down-counter
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            enabled_reg  <= 1'b0;
            interval_reg <= '0;
            cnt_reg      <= '0;
            expire_reg   <= 1'b0;
        end else begin
            expire_reg <= dec && (cnt_reg == atass_sec_t'(1));
            if (tif.load) begin
                enabled_reg  <= 1'b1;
                interval_reg <= interval_next;
                cnt_reg      <= interval_next;
            end else if (tif.reload) begin
                cnt_reg <= interval_reg;
            end else if (dec) begin
                cnt_reg <= cnt_reg - atass_sec_t'(1);
            end else if (expire_reg) begin
                cnt_reg <= interval_reg; // Rearmed for the next idle
            end
        end
    end

    a_reload_full: assert property (@(posedge core_clk) disable iff (!resetn)
        tif.reload && !tif.load |=> cnt_reg == interval_reg)
        else $error("timer not reloaded on host access");
    a_hold_not_idle: assert property (@(posedge core_clk)
        disable iff (!resetn)
        !tif.run && !tif.load && !tif.reload && !expire_reg
        |=> $stable(cnt_reg))
        else $error("timer moved outside idle");
    a_zero_code: assert property (@(posedge core_clk) disable iff (!resetn)
        tif.load && tif.code == 8'h00 |=> interval_reg == 13'd6540)
        else $error("zero code did not give 109 minutes");
    a_scale_five: assert property (@(posedge core_clk) disable iff (!resetn)
        tif.load && tif.code != 8'h00
        |=> interval_reg == 13'(5 * $past(tif.code)))
        else $error("interval not five times the code");
endmodule : atass_apd_timer

//--- src/atass_top.sv
// Standby command completion and S.M.A.R.T. error reporting
`timescale 1ns/1ns
`include "atass_consts.svh"
module atass_top import atass_pkg::*; #(
    parameter int TICK_CYCLES = `ATASS_TICK_NS / `ATASS_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Task-file command from the host side
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] features,
    input  wire logic [7:0] sector_count,
    input  wire logic [7:0] cyl_low,
    input  wire logic [7:0] cyl_high,
    input  wire logic       cmd_needs_media,
    input  wire logic       host_access,
    input  wire logic       status_read,
    // Completion and task-file answer
    output logic            intrq,
    output logic            busy,
    output logic [7:0]      device_condition_flags,
    output logic [7:0]      command_error_flags,
    output logic            standby_mode,
    // Write cache
    input  wire logic       cache_dirty,
    output logic            cache_flush_req,
    // Spindle
    input  wire logic       spindle_stopped,
    input  wire logic       spindle_at_speed,
    output logic            spin_down_req,
    output logic            spin_up_req,
    // Media command launch
    output logic            media_go,
    // S.M.A.R.T. back end
    output logic            smart_exec,
    output logic [7:0]      smart_sub,
    input  wire logic       smart_done,
    input  wire logic       smart_rd_fail,
    input  wire logic       smart_wr_fail
);
    atass_tmr_if  tif ();
    atass_state_t state_reg;
    atass_state_t state_next;
    logic         intrq_reg;
    logic         busy_reg;
    logic [7:0]   stat_reg;
    logic [7:0]   err_reg;
    logic         standby_reg;
    logic         smart_on_reg;
    logic         flush_reg;
    logic         spin_dn_reg;
    logic         spin_up_reg;
    logic         media_reg;
    logic         smart_exec_reg;
    logic [7:0]   smart_sub_reg;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic in_idle;
    logic take;
    logic is_stby_load;
    logic is_stby_keep;
    logic is_stby;
    logic is_smart;
    logic key_ok;
    logic sub_known;
    logic smart_off_bad;
    logic smart_reject;
    logic smart_local;
    logic sub_writes_q;
    logic other_wait;
    logic flush_done;
    logic auto_dn;
    logic done_ok;
    logic done_fail;
    logic [7:0] done_err;
    logic smart_end;

    // Requests are only taken in idle; busy marks only standby and S.M.A.R.T. commands until completion, not spin-down or spin-up
    assign in_idle      = (state_reg == ATASS_ST_IDLE);
    assign take         = cmd_valid && in_idle;
    assign is_stby_load = (cmd_code == `ATASS_CMD_STBY_A) ||
                          (cmd_code == `ATASS_CMD_STBY_B);
    assign is_stby_keep = (cmd_code == `ATASS_CMD_STBYI_A) ||
                          (cmd_code == `ATASS_CMD_STBYI_B);
    assign is_stby      = is_stby_load || is_stby_keep;
    assign is_smart     = (cmd_code == `ATASS_CMD_SMART);
    assign key_ok = (cyl_low == `ATASS_KEY_LOW) &&
                    (cyl_high == `ATASS_KEY_HIGH);
    assign sub_known = (features >= `ATASS_SUB_RD_ATTR &&
                        features <= `ATASS_SUB_WR_LOG) ||
                       (features >= `ATASS_SUB_ENABLE &&
                        features <= `ATASS_SUB_STATUS);
    assign smart_off_bad = !smart_on_reg &&
                           (features != `ATASS_SUB_ENABLE);
    assign smart_reject  = !key_ok || !sub_known || smart_off_bad;
    assign smart_local   = (features == `ATASS_SUB_ENABLE) ||
                           (features == `ATASS_SUB_DISABLE);
    // Write-type flag of the subcommand in flight
    assign sub_writes_q  = (smart_sub_reg == `ATASS_SUB_SAVE_ATTR) ||
                           (smart_sub_reg == `ATASS_SUB_AUTOSAVE);
    assign other_wait = cmd_needs_media &&
                        (standby_reg || !spindle_at_speed);
    assign flush_done = (state_reg == ATASS_ST_FLUSH) && !cache_dirty;
    assign auto_dn    = tif.expire && in_idle && !cmd_valid &&
                        !standby_reg;
    assign smart_end  = (state_reg == ATASS_ST_SMART) && smart_done;

    // ------------------------------------------------------------
    // Completion result
    // ------------------------------------------------------------
    // Error code: read failure first, then write failure, else abort
    assign done_err  = (smart_end && smart_rd_fail) ? `ATASS_ERR_RD_FAIL :
                       (smart_end && smart_wr_fail && sub_writes_q) ?
                       `ATASS_ERR_WR_FAIL : `ATASS_ERR_ABORT;
    assign done_fail = (take && is_smart && smart_reject) ||
                       (smart_end && (smart_rd_fail ||
                                      (smart_wr_fail && sub_writes_q)));
    assign done_ok   = (take && is_smart && !smart_reject && smart_local) ||
                       (smart_end && !done_fail) || flush_done;

    // ------------------------------------------------------------
    // Timer link
    // ------------------------------------------------------------
    // Standby loads the interval
    assign tif.load   = take && is_stby_load;
    assign tif.code   = sector_count;
    assign tif.run    = in_idle && !standby_reg && !busy_reg;
    assign tif.reload = host_access || cmd_valid;

    atass_apd_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tif      (tif)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ATASS_ST_IDLE: begin
                if (take && is_stby) begin
                    state_next = ATASS_ST_FLUSH;
                end else if (take && is_smart && !smart_reject &&
                             !smart_local) begin
                    state_next = ATASS_ST_SMART;
                end else if (take && !is_stby && !is_smart && other_wait) begin
                    state_next = ATASS_ST_SPINUP;
                end else if (auto_dn && !spindle_stopped) begin
                    state_next = ATASS_ST_SPINDN;
                end
            end
            ATASS_ST_FLUSH: begin
                if (!cache_dirty) begin
                    state_next = spindle_stopped ? ATASS_ST_IDLE :
                                                   ATASS_ST_SPINDN;
                end
            end
            ATASS_ST_SPINDN: begin
                if (spindle_stopped) state_next = ATASS_ST_IDLE;
            end
            ATASS_ST_SPINUP: begin
                if (spindle_at_speed) state_next = ATASS_ST_IDLE;
            end
            ATASS_ST_SMART: begin
                if (smart_done) state_next = ATASS_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) state_reg <= ATASS_ST_IDLE;
        else state_reg <= state_next;
    end

    // Task-file answer and interrupt; a completion beats a status read
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            intrq_reg <= 1'b0;
            busy_reg  <= 1'b0;
            stat_reg  <= `ATASS_STAT_OK;
            err_reg   <= `ATASS_ERR_NONE;
        end else begin
            if (done_ok || done_fail) begin
                intrq_reg <= 1'b1;
                busy_reg  <= 1'b0;
                stat_reg  <= done_fail ? `ATASS_STAT_FAIL : `ATASS_STAT_OK;
                err_reg   <= done_fail ? done_err : `ATASS_ERR_NONE;
            end else if (take && (is_stby || is_smart)) begin
                intrq_reg <= status_read ? 1'b0 : intrq_reg;
                busy_reg  <= 1'b1;
                stat_reg  <= `ATASS_STAT_BUSY;
            end else if (status_read) begin
                intrq_reg <= 1'b0;
            end
        end
    end

    // Standby flag and S.M.A.R.T. enable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            standby_reg  <= 1'b0;
            smart_on_reg <= 1'b0;
        end else begin
            if ((take && is_stby) || auto_dn) standby_reg <= 1'b1;
            else if (state_reg == ATASS_ST_SPINUP && spindle_at_speed)
                standby_reg <= 1'b0;
            if (take && is_smart && !smart_reject && smart_local)
                smart_on_reg <= (features == `ATASS_SUB_ENABLE);
        end
    end

    // Drive to cache, spindle and back ends
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flush_reg      <= 1'b0;
            spin_dn_reg    <= 1'b0;
            spin_up_reg    <= 1'b0;
            media_reg      <= 1'b0;
            smart_exec_reg <= 1'b0;
            smart_sub_reg  <= 8'h00;
        end else begin
            flush_reg   <= (state_next == ATASS_ST_FLUSH);
            spin_dn_reg <= (state_next == ATASS_ST_SPINDN);
            spin_up_reg <= (state_next == ATASS_ST_SPINUP);
            media_reg   <= (take && !is_stby && !is_smart && !other_wait) ||
                           (state_reg == ATASS_ST_SPINUP && spindle_at_speed);
            smart_exec_reg <= take && is_smart && !smart_reject &&
                              !smart_local;
            if (take && is_smart) smart_sub_reg <= features;
        end
    end

    assign intrq                  = intrq_reg;
    assign busy                   = busy_reg;
    assign device_condition_flags = stat_reg;
    assign command_error_flags    = err_reg;
    assign standby_mode           = standby_reg;
    assign cache_flush_req        = flush_reg;
    assign spin_down_req          = spin_dn_reg;
    assign spin_up_req            = spin_up_reg;
    assign media_go               = media_reg;
    assign smart_exec             = smart_exec_reg;
    assign smart_sub              = smart_sub_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_smart_key_err: assert property (take && is_smart && !key_ok
        |=> stat_reg == 8'h51 && err_reg == 8'h04)
        else $error("bad key not reported");
    a_smart_sub_err: assert property (take && is_smart && !sub_known
        |=> stat_reg == 8'h51 && err_reg == 8'h04 && intrq_reg)
        else $error("bad subcommand not reported");
    a_smart_off_err: assert property (take && is_smart && !smart_on_reg &&
        features != 8'hd8 |=> err_reg == 8'h04 && !smart_exec_reg)
        else $error("subcommand accepted while disabled");
    a_attr_rd_err: assert property (smart_end && smart_rd_fail
        |=> stat_reg == 8'h51 && err_reg == 8'h40)
        else $error("read failure not reported");
    a_attr_wr_err: assert property (smart_end && !smart_rd_fail &&
        smart_wr_fail && sub_writes_q |=> err_reg == 8'h01)
        else $error("write failure not reported");
    a_stby_enter: assert property (take && is_stby
        |=> standby_reg && flush_reg)
        else $error("standby not entered at once");
    a_keep_interval: assert property (take && is_stby_keep
        |=> $stable(tif.interval))
        else $error("immediate standby changed interval");
    a_flush_first: assert property (state_reg == ATASS_ST_FLUSH && cache_dirty
        |=> !$rose(intrq_reg))
        else $error("interrupt before cache drained");
    a_skip_spindn: assert property (flush_done && spindle_stopped
        |=> !spin_dn_reg && state_reg == ATASS_ST_IDLE)
        else $error("spin-down run with spindle stopped");
    a_spin_after_irq: assert property (flush_done && !spindle_stopped
        |=> intrq_reg && spin_dn_reg)
        else $error("no spin-down after interrupt");
    a_media_speed: assert property (state_reg == ATASS_ST_SPINUP &&
        !spindle_at_speed |=> !media_reg)
        else $error("media command before speed");
    a_media_launch: assert property (state_reg == ATASS_ST_SPINUP &&
        spindle_at_speed |=> media_reg && !standby_reg)
        else $error("media command not launched at speed");
    a_auto_spindn: assert property (auto_dn && !spindle_stopped
        |=> standby_reg && spin_dn_reg)
        else $error("expiry did not spin down");

    c_standby: cover property (take && is_stby_load ##[1:20] intrq_reg);
    c_smart_err: cover property (take && is_smart ##1 err_reg == 8'h04);
    c_media_wait: cover property (spin_up_reg ##[1:20] media_reg);
    c_auto: cover property (auto_dn);
endmodule : atass_top

//--- bench/atass_far_model.sv
// Far-side model: write cache, spindle and S.M.A.R.T. back end
`timescale 1ns/1ns
module atass_far_model (
    // Clock, reset, bench controls
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic mark_dirty,
    input  wire logic rd_fail_cfg,
    input  wire logic wr_fail_cfg,
    // Requests from the device logic
    input  wire logic cache_flush_req,
    input  wire logic spin_down_req,
    input  wire logic spin_up_req,
    input  wire logic smart_exec,
    // Answers
    output logic      cache_dirty,
    output logic      spindle_stopped,
    output logic      spindle_at_speed,
    output logic      smart_done,
    output logic      smart_rd_fail,
    output logic      smart_wr_fail
);
    logic [2:0] cnt_reg;
    logic [1:0] sm_reg;
    wire        act = cache_flush_req | spin_down_req | spin_up_req;
    wire        hit = cnt_reg == 3'h4;
    // Slow on purpose: cache and spindle requests are answered only after five cycles, S.M.A.R.T. after two
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 3'h0;
            sm_reg <= 2'h0;
            cache_dirty <= 1'b0;
            spindle_stopped <= 1'b0;
        end else begin
            cnt_reg <= act ? cnt_reg + 3'h1 : 3'h0;
            sm_reg <= {sm_reg[0], smart_exec};
            if (mark_dirty) cache_dirty <= 1'b1;
            else if (cache_flush_req && hit) cache_dirty <= 1'b0;
            if (spin_down_req && hit) spindle_stopped <= 1'b1;
            else if (spin_up_req && hit) spindle_stopped <= 1'b0;
        end
    end
    // Fail flags show the inverted setting outside the done pulse
    assign smart_done = sm_reg[1];
    assign smart_rd_fail = smart_done ? rd_fail_cfg : ~rd_fail_cfg;
    assign smart_wr_fail = smart_done ? wr_fail_cfg : ~wr_fail_cfg;
    assign spindle_at_speed = ~spindle_stopped;
endmodule : atass_far_model

//--- bench/ata_standby_and_smart_status_tb.sv
// Command-level testbench for the standby and S.M.A.R.T. status block
`timescale 1ns/1ns
module ata_standby_and_smart_status_tb;
    logic core_clk, resetn, cmd_valid, cmd_needs_media, host_access;
    logic status_read, intrq, busy, standby_mode, cache_dirty;
    logic cache_flush_req, spindle_stopped, spindle_at_speed, spin_down_req;
    logic spin_up_req, media_go, smart_exec, smart_done, smart_rd_fail;
    logic smart_wr_fail, mark_dirty, rd_fail_cfg, wr_fail_cfg;
    logic [7:0] cmd_code, features, sector_count, cyl_low, cyl_high;
    logic [7:0] device_condition_flags, command_error_flags, smart_sub;
    int n_fail = 0, n_tests = 0, n, i;
    logic [7:0] t_sub [9] = '{8'hd0, 8'hd8, 8'hd0, 8'hd7, 8'hd0, 8'hd3,
        8'hd0, 8'hd9, 8'hd0};
    logic [7:0] t_hi [9] = '{8'hc2, 8'hc2, 8'h00, 8'hc2, 8'hc2, 8'hc2,
        8'hc2, 8'hc2, 8'hc2};
    logic [7:0] t_err [9] = '{8'h04, 8'h00, 8'h04, 8'h04, 8'h40, 8'h01,
        8'h00, 8'h00, 8'h04};

    atass_top #(.TICK_CYCLES(10)) DUT (
        .core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .features(features), .busy(busy),
        .sector_count(sector_count), .cyl_low(cyl_low), .intrq(intrq),
        .cyl_high(cyl_high), .cmd_needs_media(cmd_needs_media),
        .host_access(host_access), .status_read(status_read),
        .device_condition_flags(device_condition_flags),
        .command_error_flags(command_error_flags), .media_go(media_go),
        .standby_mode(standby_mode), .cache_dirty(cache_dirty),
        .cache_flush_req(cache_flush_req), .smart_exec(smart_exec),
        .spindle_stopped(spindle_stopped), .spin_up_req(spin_up_req),
        .spindle_at_speed(spindle_at_speed), .spin_down_req(spin_down_req),
        .smart_sub(smart_sub), .smart_done(smart_done),
        .smart_rd_fail(smart_rd_fail), .smart_wr_fail(smart_wr_fail));
    atass_far_model far (
        .core_clk(core_clk), .resetn(resetn), .mark_dirty(mark_dirty),
        .rd_fail_cfg(rd_fail_cfg), .wr_fail_cfg(wr_fail_cfg),
        .cache_flush_req(cache_flush_req), .spin_down_req(spin_down_req),
        .spin_up_req(spin_up_req), .smart_exec(smart_exec),
        .cache_dirty(cache_dirty), .spindle_stopped(spindle_stopped),
        .spindle_at_speed(spindle_at_speed), .smart_done(smart_done),
        .smart_rd_fail(smart_rd_fail), .smart_wr_fail(smart_wr_fail));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : check
    // Task-file write; held across the one taking edge
    task automatic cmd(input logic [7:0] c, f, s, h, input logic m);
        @(negedge core_clk);
        {cmd_valid, cmd_code, features, sector_count} = {1'b1, c, f, s};
        {cyl_high, cmd_needs_media} = {h, m};
        @(negedge core_clk);
        {cmd_valid, cmd_needs_media} = 2'b00;
    endtask : cmd
    // Bounded wait; a hang counts as a mismatch and ends the run
    task automatic wait_on(input int w, output int cnt);
        logic hit;
        cnt = 0;
        forever begin
            case (w)
                0: hit = intrq === 1'b1 && busy === 1'b0;
                1: hit = spindle_stopped === 1'b1 && spin_down_req === 1'b0;
                2: hit = media_go === 1'b1;
                default: hit = standby_mode === 1'b1;
            endcase
            if (hit) break;
            if (cnt > 70000) begin
                n_fail++;
                summarize();
            end
            @(negedge core_clk);
            cnt++;
        end
    endtask : wait_on
    // Completion: result codes, then a status read clears intrq
    task automatic done_chk(input logic [7:0] s, e);
        wait_on(0, n);
        check("cache_dirty", cache_dirty, 8'h00); // flush first
        check("status", device_condition_flags, s);
        check("error", command_error_flags, e);
        status_read = 1'b1;
        @(negedge core_clk);
        status_read = 1'b0;
    endtask : done_chk

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {resetn, cmd_valid, cmd_needs_media, host_access, status_read} = 0;
        {mark_dirty, rd_fail_cfg, wr_fail_cfg} = 3'b000;
        {cmd_code, features, sector_count, cyl_high} = 32'h0;
        cyl_low = 8'h4f;
        repeat (3) @(negedge core_clk);
        resetn = 1'b1;
        check("status rst", device_condition_flags, 8'h50);
        check("error rst", command_error_flags, 8'h00);
        // Off, on, bad key, bad sub, read fail, write fail, ok, off, refused
        for (i = 0; i < 9; i++) begin
            {rd_fail_cfg, wr_fail_cfg} = {i == 4, i == 5};
            cmd(8'hb0, t_sub[i], 8'h00, t_hi[i], 1'b0);
            done_chk(t_err[i] == 8'h00 ? 8'h50 : 8'h51, t_err[i]);
            check("sub", smart_sub, t_sub[i]);
        end
        // Standby with dirty cache, then standby immediate when stopped
        mark_dirty = 1'b1;
        @(negedge core_clk);
        mark_dirty = 1'b0;
        cmd(8'he2, 8'h00, 8'h01, 8'h00, 1'b0);
        check("standby e2", standby_mode, 8'h01);
        check("flush", cache_flush_req, 8'h01);
        done_chk(8'h50, 8'h00);
        wait_on(1, n); // spin down
        cmd(8'he0, 8'h00, 8'h07, 8'h00, 1'b0);
        check("standby e0", standby_mode, 8'h01);
        done_chk(8'h50, 8'h00);
        repeat (5) @(negedge core_clk);
        check("no spin down", spin_down_req, 8'h00); // skip
        // Media command waits for speed; timer kept alive by accesses
        cmd(8'h20, 8'h00, 8'h00, 8'h00, 1'b1);
        check("spin up", spin_up_req, 8'h01);
        wait_on(2, n);
        check("at speed", spindle_at_speed, 8'h01);
        repeat (6) begin
            repeat (20) @(negedge core_clk);
            host_access = 1'b1;
            @(negedge core_clk);
            host_access = 1'b0;
        end
        check("reloaded", standby_mode, 8'h00);
        wait_on(3, n);
        check("apd 5s", n >= 38 && n <= 52, 8'h01);
        wait_on(1, n);
        cmd(8'h94, 8'h00, 8'h00, 8'h00, 1'b0);
        done_chk(8'h50, 8'h00);
        // Zero code: 109 minutes, counted only once idle again
        cmd(8'h96, 8'h00, 8'h00, 8'h00, 1'b0);
        done_chk(8'h50, 8'h00);
        cmd(8'h20, 8'h00, 8'h00, 8'h00, 1'b1);
        wait_on(2, n);
        wait_on(3, n);
        check("apd 0", n >= 65380 && n <= 65402, 8'h01);
        summarize();
    end
endmodule : ata_standby_and_smart_status_tb
